// ==== hdl/spalm_pkg.sv ====
// Shared constants, modes and carrier types of the alternative line modes
// port. Assumes a single system clock; no register bus, all controls are
// plain ports of the top module.
package spalm_pkg;

    // Line mode field encodings
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_RS485 = 4'h1;
    localparam logic [3:0] MODE_MODEM = 4'h3;
    localparam logic [3:0] MODE_T1 = 4'h6;
    localparam logic [3:0] MODE_IRDA = 4'h8;

    // Channel test mode encodings
    localparam logic [1:0] CH_NORMAL = 2'h0;
    localparam logic [1:0] CH_ECHO = 2'h1;
    localparam logic [1:0] CH_LOCAL = 2'h2;
    localparam logic [1:0] CH_REMOTE = 2'h3;

    // Sixteen oversampling slots per bit period
    localparam logic [3:0] SUB_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_SLOT = 4'h7;
    localparam logic [3:0] IR_PULSE_SLOTS = 4'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Pin synchroniser bit positions
    localparam int PIN_RXD = 0;
    localparam int PIN_CTS = 1;
    localparam int PIN_DCD = 2;
    localparam int PIN_DSR = 3;
    localparam int PIN_RI = 4;
    localparam int PIN_COUNT = 5;

    localparam int DATA_BITS = 8;
    localparam int CD_WIDTH = 16;

    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] chmode;
        logic [CD_WIDTH-1:0] clock_divisor;
        logic [7:0] timeguard;
        logic [7:0] ir_filter;
        logic par_en;
        logic par_odd;
        logic tx_en;
        logic rx_en;
    } spalm_cfg_t;

    typedef struct packed {
        logic ri;
        logic dsr;
        logic dcd;
        logic cts;
    } spalm_modem_t;

    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GUARD
    } spalm_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } spalm_rx_state_t;

    typedef enum logic [1:0] {
        FLT_IDLE, FLT_COUNT, FLT_HOLD
    } spalm_flt_state_t;

endpackage

// ==== hdl/spalm_fifo.sv ====
// Transmit character FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module spalm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    import spalm_pkg::*;

    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
            $error("spalm_fifo: DEPTH must be a power of two above 1");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
        logic full;
        logic empty;
    } spalm_fifo_st_t;

    spalm_fifo_st_t st;
    spalm_fifo_st_t next_st;
    logic push;
    logic pop;
    logic [AW:0] cnt;

    assign push = in_valid_in && !st.full;
    assign pop = out_ready_in && !st.empty;

    always_comb begin
        next_st = st;
        cnt = st.count;
        if (push) begin
            next_st.mem[st.wr] = in_data_in;
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        if (push && !pop) begin
            cnt = st.count + 1'b1;
        end else if (pop && !push) begin
            cnt = st.count - 1'b1;
        end
        next_st.count = cnt;
        // Flags registered so both ready and valid come from flip-flops
        next_st.full = (cnt == (AW + 1)'(DEPTH));
        next_st.empty = (cnt == '0);
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st <= '{mem: '0, wr: '0, rd: '0, count: '0, full: 1'b0,
                    empty: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign in_ready_out = !st.full;
    assign out_valid_out = !st.empty;
    assign out_data_out = st.mem[st.rd];

endmodule
`default_nettype wire

// ==== hdl/spalm_ir_demod.sv ====
// Infrared receive pulse filter and demodulator.
// Assumes line_in is already synchronised to clk_sys_in and os_tick_in is
// the sixteen-per-bit oversampling enable.
`timescale 1ns/1ps
`default_nettype none
module spalm_ir_demod (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic enable_in,
    input wire logic line_in,
    input wire logic [7:0] filter_in,
    input wire logic os_tick_in,
    output logic demod_out
);
    import spalm_pkg::*;

    typedef struct packed {
        spalm_flt_state_t fsm;
        logic prev;
        logic [7:0] cnt;
        logic [3:0] slot;
        logic out;
    } spalm_dem_st_t;

    spalm_dem_st_t st;
    spalm_dem_st_t next_st;
    logic fall;
    logic rise;

    assign fall = st.prev && !line_in;
    assign rise = !st.prev && line_in;

    always_comb begin
        next_st = st;
        next_st.prev = line_in;
        case (st.fsm)
            FLT_IDLE: begin
                next_st.cnt = filter_in;
                next_st.out = 1'b1;
                if (fall) begin
                    next_st.fsm = FLT_COUNT;
                end
            end
            FLT_COUNT: begin
                if (rise) begin
                    // Too short: a glitch, not a light pulse
                    next_st.fsm = FLT_IDLE;
                    next_st.cnt = filter_in;
                end else if (st.cnt == 8'h00) begin
                    next_st.fsm = FLT_HOLD;
                    next_st.out = 1'b0;
                    next_st.slot = '0;
                end else begin
                    next_st.cnt = st.cnt - 8'h01;
                end
            end
            FLT_HOLD: begin
                if (fall) begin
                    // Next zero bit arrives before the hold ends: keep low
                    next_st.fsm = FLT_COUNT;
                    next_st.cnt = filter_in;
                end else if (os_tick_in) begin
                    next_st.slot = st.slot + 4'h1;
                    if (st.slot == SUB_LAST) begin
                        // Low held for exactly one bit period
                        next_st.fsm = FLT_IDLE;
                        next_st.out = 1'b1;
                        next_st.cnt = filter_in;
                    end
                end
            end
            default: begin
                next_st.fsm = FLT_IDLE;
            end
        endcase
        if (!enable_in) begin
            next_st.fsm = FLT_IDLE;
            next_st.out = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st <= '{fsm: FLT_IDLE, prev: 1'b1, cnt: '0, slot: '0,
                    out: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign demod_out = st.out;

endmodule
`default_nettype wire

// ==== hdl/spalm_top.sv ====
// Serial port alternative line modes: character engine with smart-card
// T=1 framing, infrared modulator and demodulator, RS485 driver enable,
// modem lines with change flags and the four channel test modes.
// Assumes all pins are asynchronous to clk_sys_in; controls are plain ports
// driven from logic on clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module spalm_top #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire spalm_pkg::spalm_cfg_t cfg_in,
    input wire logic term_ready_on_cmd_in,
    input wire logic term_ready_off_cmd_in,
    input wire logic status_read_in,
    input wire logic reset_status_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    output logic parity_error_flag_out,
    output logic tx_idle_flag_out,
    output spalm_pkg::spalm_modem_t modem_change_out,
    input wire logic rxd_in,
    input wire logic cts_in,
    input wire logic dcd_in,
    input wire logic dsr_in,
    input wire logic ri_in,
    output logic txd_out,
    output logic rts_out,
    output logic dtr_out
);
    import spalm_pkg::*;

    generate
        if (FIFO_DEPTH < 2) begin : g_chk
            $error("spalm_top: FIFO_DEPTH must be at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [PIN_COUNT-1:0] meta;
        logic [PIN_COUNT-1:0] sync;
        logic [CD_WIDTH-1:0] div_cnt;
        logic os_tick;
        spalm_tx_state_t tx_st;
        logic [3:0] tx_sub;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic [7:0] tg_cnt;
        logic tx_line;
        spalm_rx_state_t rx_st;
        logic [3:0] rx_sub;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        logic [7:0] rx_data;
        logic rx_valid;
        logic par_err;
        logic [3:0] mdm_prev;
        spalm_modem_t chg;
        logic txd;
        logic rts;
        logic dtr;
        logic tx_idle;
    } spalm_st_t;

    spalm_st_t st;
    spalm_st_t next_st;

    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic demod_line;

    logic is_irda;
    logic is_t1;
    logic is_rs485;
    logic is_modem;
    logic par_used;
    logic par_odd;
    logic tx_allowed;
    logic rx_on;
    logic rx_line;
    logic ir_pulse;
    logic [3:0] mdm_now;

    assign is_irda = (cfg_in.mode == MODE_IRDA);
    assign is_t1 = (cfg_in.mode == MODE_T1);
    assign is_rs485 = (cfg_in.mode == MODE_RS485);
    assign is_modem = (cfg_in.mode == MODE_MODEM);
    // T=1 ignores the programmed parity and always uses even parity
    assign par_used = is_t1 || cfg_in.par_en;
    assign par_odd = is_t1 ? 1'b0 : cfg_in.par_odd;
    // In modem mode a new character waits while CTS is inactive; the one in flight ends
    assign tx_allowed = cfg_in.tx_en && (cfg_in.chmode != CH_REMOTE)
                        && !(is_modem && st.sync[PIN_CTS]);
    assign rx_on = cfg_in.rx_en && (cfg_in.chmode != CH_REMOTE);
    assign mdm_now = {st.sync[PIN_RI], st.sync[PIN_DSR], st.sync[PIN_DCD],
                      st.sync[PIN_CTS]};
    // Start on a tick so the first slot, and its light pulse, is whole
    assign fifo_pop = (st.tx_st == TX_IDLE) && fifo_valid && tx_allowed
                      && st.os_tick;

    spalm_fifo #(
        .WIDTH(DATA_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .in_data_in(tx_data_in),
        .in_valid_in(tx_valid_in),
        .in_ready_out(tx_ready_out),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop)
    );

    spalm_ir_demod u_demod (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .enable_in(is_irda),
        .line_in(st.sync[PIN_RXD]),
        .filter_in(cfg_in.ir_filter),
        .os_tick_in(st.os_tick),
        .demod_out(demod_line)
    );

    // Receiver input selection per channel mode
    always_comb begin
        case (cfg_in.chmode)
            CH_LOCAL: rx_line = st.tx_line;
            CH_NORMAL,
            CH_ECHO: rx_line = is_irda ? demod_line
                                       : st.sync[PIN_RXD];
            default: rx_line = 1'b1;
        endcase
    end

    // A zero lights the diode for the first three of sixteen slots
    assign ir_pulse = (st.tx_st != TX_IDLE) && (st.tx_st != TX_GUARD)
                      && !st.tx_line
                      && (st.tx_sub < IR_PULSE_SLOTS);

    always_comb begin
        next_st = st;

        // Two-flop synchronisers on every pin input
        next_st.meta = {ri_in, dsr_in, dcd_in, cts_in, rxd_in};
        next_st.sync = st.meta;

        // Oversampling divider: one enable per sixteenth of a bit; the
        // full divisor width covers the slowest infrared rates too
        next_st.os_tick = 1'b0;
        if (cfg_in.clock_divisor == '0) begin
            next_st.div_cnt = '0;
        end else if (st.div_cnt >= cfg_in.clock_divisor - 1'b1) begin
            next_st.div_cnt = '0;
            next_st.os_tick = 1'b1;
        end else begin
            next_st.div_cnt = st.div_cnt + 1'b1;
        end

        // Transmitter
        if (fifo_pop) begin
            next_st.tx_st = TX_START;
            next_st.tx_sh = fifo_data;
            next_st.tx_sub = '0;
            next_st.tx_bit = '0;
            next_st.tx_par = 1'b0;
            next_st.tx_line = 1'b0;
        end else if (st.os_tick && st.tx_st != TX_IDLE) begin
            next_st.tx_sub = st.tx_sub + 4'h1;
            if (st.tx_sub == SUB_LAST) begin
                case (st.tx_st)
                    TX_START: begin
                        next_st.tx_st = TX_DATA;
                        next_st.tx_line = st.tx_sh[0];
                    end
                    TX_DATA: begin
                        next_st.tx_par = st.tx_par ^ st.tx_sh[0];
                        next_st.tx_sh = {1'b0, st.tx_sh[7:1]};
                        next_st.tx_bit = st.tx_bit + 3'h1;
                        if (st.tx_bit == BIT_LAST) begin
                            if (par_used) begin
                                next_st.tx_st = TX_PAR;
                                next_st.tx_line = st.tx_par ^ st.tx_sh[0]
                                                  ^ par_odd;
                            end else begin
                                next_st.tx_st = TX_STOP;
                                next_st.tx_line = 1'b1;
                            end
                        end else begin
                            next_st.tx_line = st.tx_sh[1];
                        end
                    end
                    TX_PAR: begin
                        next_st.tx_st = TX_STOP;
                        next_st.tx_line = 1'b1;
                    end
                    TX_STOP: begin
                        // Single stop bit, then the optional timeguard
                        if (cfg_in.timeguard != 8'h00) begin
                            next_st.tx_st = TX_GUARD;
                            next_st.tg_cnt = cfg_in.timeguard;
                        end else begin
                            next_st.tx_st = TX_IDLE;
                        end
                    end
                    TX_GUARD: begin
                        next_st.tg_cnt = st.tg_cnt - 8'h01;
                        if (st.tg_cnt == 8'h01) begin
                            next_st.tx_st = TX_IDLE;
                        end
                    end
                    default: begin
                        next_st.tx_st = TX_IDLE;
                        next_st.tx_line = 1'b1;
                    end
                endcase
            end
        end
        // Guard bits count as busy so the driver stays on through them
        next_st.tx_idle = (next_st.tx_st == TX_IDLE) && !fifo_valid;

        // Receiver: samples in the middle of each bit period
        next_st.rx_valid = 1'b0;
        if (!rx_on) begin
            next_st.rx_st = RX_IDLE;
        end else if (st.rx_st == RX_IDLE) begin
            if (!rx_line) begin
                next_st.rx_st = RX_START;
                next_st.rx_sub = '0;
                next_st.rx_bit = '0;
                next_st.rx_par = 1'b0;
            end
        end else if (st.os_tick) begin
            next_st.rx_sub = st.rx_sub + 4'h1;
            if (st.rx_sub == SAMPLE_SLOT) begin
                case (st.rx_st)
                    RX_START: begin
                        if (rx_line) begin
                            next_st.rx_st = RX_IDLE;
                        end
                    end
                    RX_DATA: begin
                        next_st.rx_sh = {rx_line, st.rx_sh[7:1]};
                        next_st.rx_par = st.rx_par ^ rx_line;
                    end
                    RX_PAR: begin
                        next_st.rx_par = st.rx_par ^ rx_line;
                    end
                    RX_STOP: begin
                        next_st.rx_st = RX_IDLE;
                        next_st.rx_data = st.rx_sh;
                        next_st.rx_valid = 1'b1;
                        if (par_used && (st.rx_par ^ par_odd)) begin
                            next_st.par_err = 1'b1;
                        end
                    end
                    default: begin
                        next_st.rx_st = RX_IDLE;
                    end
                endcase
            end else if (st.rx_sub == SUB_LAST) begin
                case (st.rx_st)
                    RX_START: next_st.rx_st = RX_DATA;
                    RX_DATA: begin
                        next_st.rx_bit = st.rx_bit + 3'h1;
                        if (st.rx_bit == BIT_LAST) begin
                            next_st.rx_st = par_used ? RX_PAR : RX_STOP;
                        end
                    end
                    RX_PAR: next_st.rx_st = RX_STOP;
                    default: next_st.rx_st = st.rx_st;
                endcase
            end
        end
        // A same-cycle error survives the clear only if the flag was not set before
        if (reset_status_in && !(next_st.par_err && !st.par_err)) begin
            next_st.par_err = 1'b0;
        end

        // Modem change flags: a change in the read cycle survives
        next_st.mdm_prev = mdm_now;
        next_st.chg = status_read_in ? '0 : st.chg;
        if (is_modem) begin
            next_st.chg = next_st.chg | (mdm_now ^ st.mdm_prev);
        end

        // Terminal ready: disable wins if both commands come together
        if (is_modem && term_ready_on_cmd_in) begin
            next_st.dtr = 1'b0;
        end
        if (is_modem && term_ready_off_cmd_in) begin
            next_st.dtr = 1'b1;
        end

        // Request to send
        if (is_rs485) begin
            next_st.rts = !next_st.tx_idle;
        end else if (is_modem) begin
            next_st.rts = !cfg_in.tx_en;
        end else begin
            next_st.rts = 1'b1;
        end

        // Transmit pin per channel mode; in CH_NORMAL the infrared line idles dark
        case (cfg_in.chmode)
            CH_NORMAL: next_st.txd = is_irda ? ir_pulse
                                             : st.tx_line;
            CH_ECHO: next_st.txd = st.sync[PIN_RXD];
            CH_LOCAL: next_st.txd = 1'b1;
            default: next_st.txd = st.sync[PIN_RXD];
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st <= '{meta: '1, sync: '1, div_cnt: '0, os_tick: 1'b0,
                    tx_st: TX_IDLE, tx_sub: '0, tx_bit: '0, tx_sh: '0,
                    tx_par: 1'b0, tg_cnt: '0, tx_line: 1'b1,
                    rx_st: RX_IDLE, rx_sub: '0, rx_bit: '0, rx_sh: '0,
                    rx_par: 1'b0, rx_data: '0, rx_valid: 1'b0,
                    par_err: 1'b0, mdm_prev: '1, chg: '0, txd: 1'b1,
                    rts: 1'b1, dtr: 1'b1, tx_idle: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign rx_data_out = st.rx_data;
    assign rx_valid_out = st.rx_valid;
    assign parity_error_flag_out = st.par_err;
    assign tx_idle_flag_out = st.tx_idle;
    assign modem_change_out = st.chg;
    assign txd_out = st.txd;
    assign rts_out = st.rts;
    assign dtr_out = st.dtr;

endmodule
`default_nettype wire

// ==== test/spalm_properties.sv ====
// Checker on the top ports: test modes, line pins and modem flags.
// Assumes one clock; bound to every spalm_top by the bind below.
`timescale 1ns/1ps
`default_nettype none
module spalm_properties import spalm_pkg::*; (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire spalm_pkg::spalm_cfg_t cfg_in,
    input wire logic term_ready_on_cmd_in,
    input wire logic term_ready_off_cmd_in,
    input wire logic status_read_in,
    input wire logic tx_idle_flag_out,
    input wire spalm_pkg::spalm_modem_t modem_change_out,
    input wire logic rxd_in,
    input wire logic cts_in,
    input wire logic dcd_in,
    input wire logic dsr_in,
    input wire logic ri_in,
    input wire logic txd_out,
    input wire logic rts_out,
    input wire logic dtr_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);
    logic [15:0] hi_cnt;
    // Length of the current high run, to measure light pulses
    always_ff @(posedge clk_sys_in)
        hi_cnt <= (txd_out && !srst_in) ? hi_cnt + 16'h1 : 16'h0;
    // Pins held long enough that no change is still in the synchroniser
    sequence pins_quiet;
        $stable({ri_in, dsr_in, dcd_in, cts_in}) [*6];
    endsequence
    // Mode switches and reset also end a high run, so they are excluded
    sequence ir_fall;
        cfg_in.mode == MODE_IRDA && $past(cfg_in.mode, 2) == MODE_IRDA &&
            cfg_in.chmode == CH_NORMAL && $fell(txd_out) &&
            !$past(srst_in, 2);
    endsequence
    AST_LOCAL_IDLE: assert property (
        cfg_in.chmode == CH_LOCAL |=> txd_out)
        else $error("line not idle in local loopback");
    AST_ECHO_COPY: assert property (
        cfg_in.chmode[0] [*4] |-> txd_out == $past(rxd_in, 3))
        else $error("line not copied in echo");
    AST_RS485_RTS: assert property (
        cfg_in.mode == MODE_RS485 |=> rts_out == !tx_idle_flag_out)
        else $error("rts not inverse of idle");
    AST_DTR_OFF: assert property (
        cfg_in.mode == MODE_MODEM && term_ready_off_cmd_in |=> dtr_out)
        else $error("dtr not high after off");
    AST_DTR_ON: assert property (
        cfg_in.mode == MODE_MODEM && term_ready_on_cmd_in &&
        !term_ready_off_cmd_in |=> !dtr_out)
        else $error("dtr not low after on");
    AST_FLAG_STICKY: assert property (
        !status_read_in |=> (modem_change_out & $past(modem_change_out))
        == $past(modem_change_out))
        else $error("change flag lost");
    AST_FLAG_CLEAR: assert property (
        pins_quiet ##0 status_read_in |=> modem_change_out == 4'h0)
        else $error("change flags not cleared");
    AST_IR_PULSE: assert property (
        ir_fall |-> hi_cnt == cfg_in.clock_divisor * 16'h3)
        else $error("light pulse length wrong");
endmodule
bind spalm_top spalm_properties chk (.*);
`default_nettype wire

// ==== test/spalm_partner.sv ====
// Line-side partner: infrared transceiver or plain wire back to receive,
// or a level pattern from the bench when not looped.
`timescale 1ns/1ps
`default_nettype none
module spalm_partner (
    input wire logic txd_in,
    input wire logic loop_in,
    input wire logic ir_in,
    input wire logic pat_in,
    output logic rxd_out
);
    // Light seen pulls the transceiver's receive output low
    assign rxd_out = loop_in ? (ir_in ? !txd_in : txd_in) : pat_in;
endmodule
`default_nettype wire

// ==== test/tb_serial_port_alt_line_modes.sv ====
// Bench: round trips via the partner in each line mode, test modes,
// modem lines and the transmit buffer. Assumes the checker binds itself.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_alt_line_modes;
    import spalm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1, on = 1'b0, off = 1'b0, rd = 1'b0, vld = 1'b0;
    logic loop = 1'b1, pat = 1'b1, rdy, rxv, perr, idle, rxd, txd, rts, dtr;
    logic [7:0] txb = 8'h00, rxb;
    logic [8:0] fr;
    logic [7:0] q [17];
    logic [3:0] pins = 4'h0;
    logic [31:0] seed = 32'h0129;
    logic [3:0] modes [5] = '{MODE_NORMAL, MODE_MODEM, MODE_T1, MODE_IRDA,
        MODE_RS485};
    spalm_cfg_t cfg = '0;
    spalm_modem_t chg;
    int failures = 0, tests_run = 0, cycles = 0, n = 0;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            give_verdict();
        end
    end
    spalm_top #(.FIFO_DEPTH(16)) uut (.clk_sys_in(clk), .srst_in(rst),
        .cfg_in(cfg), .term_ready_on_cmd_in(on), .term_ready_off_cmd_in(off),
        .status_read_in(rd), .reset_status_in(1'b0), .tx_data_in(txb),
        .tx_valid_in(vld), .tx_ready_out(rdy), .rx_data_out(rxb),
        .rx_valid_out(rxv), .parity_error_flag_out(perr),
        .tx_idle_flag_out(idle), .modem_change_out(chg), .rxd_in(rxd),
        .cts_in(pins[0]), .dcd_in(pins[1]), .dsr_in(pins[2]),
        .ri_in(pins[3]), .txd_out(txd), .rts_out(rts), .dtr_out(dtr));
    spalm_partner line (.txd_in(txd), .loop_in(loop), .pat_in(pat),
        .ir_in(cfg.mode == MODE_IRDA), .rxd_out(rxd));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask
    task automatic push(input logic [7:0] d);
        txb = d;
        vld = 1'b1;
        tick(1);
        vld = 1'b0;
    endtask
    task automatic expect_rx(input logic [7:0] d);
        n = 0;
        while (rxv !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        `CHK(rxb, d)
        tick(1);
    endtask
    task automatic give_verdict();
        $display("Compares %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        cfg.clock_divisor = 16'h0002;
        cfg.timeguard = 8'h02;
        cfg.ir_filter = 8'h03;
        cfg.tx_en = 1'b1;
        cfg.rx_en = 1'b1;
        tick(20);
        rst = 1'b0;
        foreach (modes[i]) begin
            while (idle !== 1'b1) tick(1);
            cfg.mode = modes[i];
            cfg.par_en = seed[9];
            cfg.par_odd = seed[10];
            seed = lfsr(seed);
            push(seed[7:0]);
            expect_rx(seed[7:0]);
        end
        `CHK(rts, 1'b1)
        while (idle !== 1'b1) tick(1);
        tick(2);
        `CHK(rts, 1'b0)
        `CHK(perr, 1'b0)
        cfg.mode = MODE_IRDA;
        cfg.ir_filter = 8'h08;
        push(8'h00);
        n = 0;
        repeat (600) begin
            tick(1);
            n += (rxv === 1'b1);
        end
        `CHK(n, 0)
        // Receive-only infrared frame from the far side, parity off
        cfg.ir_filter = 8'h03;
        cfg.par_en = 1'b0;
        cfg.tx_en = 1'b0;
        loop = 1'b0;
        seed = lfsr(seed);
        fr = {seed[7:0], 1'b0};
        for (int b = 0; b < 9; b++) begin
            pat = fr[b];
            tick(6);
            pat = 1'b1;
            tick(26);
        end
        expect_rx(seed[7:0]);
        cfg.tx_en = 1'b1;
        cfg.mode = MODE_NORMAL;
        cfg.chmode = CH_LOCAL;
        loop = 1'b0;
        pat = 1'b0;
        push(8'ha5);
        expect_rx(8'ha5);
        for (int k = 0; k < 400; k++) begin
            cfg.chmode = k < 200 ? CH_ECHO : CH_REMOTE;
            seed = lfsr(seed);
            pat = seed[0];
            if (k == 250) push(8'h3c);
            tick(1);
        end
        `CHK(idle, 1'b0)
        pat = 1'b1;
        cfg.chmode = CH_NORMAL;
        loop = 1'b1;
        expect_rx(8'h3c);
        while (idle !== 1'b1) tick(1);
        cfg.mode = MODE_MODEM;
        pulse(off);
        `CHK(dtr, 1'b1)
        pulse(on);
        `CHK(dtr, 1'b0)
        pulse(rd);
        for (int i = 3; i >= 0; i--) begin
            pins[i] = 1'b1;
            tick(8);
            `CHK(chg, 4'h1 << i)
            pulse(rd);
            `CHK(chg, 4'h0)
        end
        for (int i = 0; i < 17; i++) begin
            seed = lfsr(seed);
            q[i] = seed[7:0];
            txb = q[i];
            vld = 1'b1;
            tick(1);
        end
        vld = 1'b0;
        `CHK(rdy, 1'b0)
        tick(400);
        `CHK(idle, 1'b0)
        pins[0] = 1'b0;
        for (int i = 0; i < 16; i++) expect_rx(q[i]);
        give_verdict();
    end
endmodule
`default_nettype wire
